// *** logic/pcg_loader.sv ***
// power-up configuration loader with pin function decode
// Function
// - after reset release the store holds default values until reprogrammed.
// - all clock output enables are off out of reset, except output zero when pin 2 is high.
// - pin 2 high enables differential output zero without software.
// - configuration is a store of 768 bytes.
// - store written only by default fill, one-time image load, or host writes.
// - pins 5,6 select one of four one-time image slots.
// - host writes are volatile and lost on reset.
// - pin functions set only by the store, written by image load or host writes.
// - bits 6:0 of each pin function-select byte choose function.
// - code 0x00 makes the pin a plain input.
// - codes 0x10-0x17 give external signal loss for references 0-7.
// - codes 0x20,0x28,0x30,0x38 OR pin into loop error-clear enables.
// - codes 0x44,0x45 OR pin into synthesizer zero halt bits 1,0.
// - straps 1:0 select master clock 24.576, 49.152, 20 MHz, reserved.
module pcg_loader #(
	parameter int unsigned HOLD_CYC  = pcg_pkg::STRAP_HOLD_CYC, // strap hold window
	parameter bit          OTP_VALID = 1'b0                     // slots programmed
) (
	input  wire logic                       sys_clk_i,    // 20 MHz clock
	input  wire logic                       reset_n_i,    // async power-on reset
	input  wire logic [pcg_pkg::NUM_PINS-1:0] pin_i,      // general-purpose pins
	input  wire pcg_pkg::pcg_wr_t           host_wr_i,    // host byte write
	input  wire pcg_pkg::pcg_rd_t           host_rd_i,    // host byte read
	output logic [1:0]                      otp_slot_o,   // slot being read
	output logic [9:0]                      otp_addr_o,   // image byte address
	input  wire logic [7:0]                 otp_data_i,   // image byte, one cycle
	output logic                            load_done_o,  // store ready for host
	output logic                            host_wr_ack_o,// write taken
	output logic [7:0]                      host_rd_o,    // read data
	output logic                            host_rd_vld_o,// read data valid
	output pcg_pkg::pcg_mclk_t              mclk_sel_o,   // master clock choice
	output logic [4:0]                      straps_o,     // latched straps 0,1,3,4,2
	output pcg_pkg::pcg_ctl_t               ctl_o         // decoded control
);
	typedef enum logic [1:0] {ST_HOLD, ST_LOAD, ST_RUN} pcg_state_t;

	// storage
	logic [7:0]       store_q [pcg_pkg::STORE_DEPTH];
	logic [7:0]       pin_m_q, pin_s_q;
	pcg_state_t       state_q, state_d;
	logic [22:0]      cnt_q, cnt_d;
	logic [9:0]       addr_q, addr_d;
	logic [1:0]       slot_q, slot_d;
	logic [4:0]       strap_q, strap_d;
	logic             done_q, done_d;
	logic             ack_q, ack_d;
	logic [7:0]       rd_q, rd_d;
	logic             rdv_q, rdv_d;
	pcg_pkg::pcg_ctl_t ctl_q, ctl_d;
	logic             wr_en;
	logic [9:0]       wr_addr;
	logic [7:0]       wr_data;

	// two-stage pin synchroniser
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pin_m_q <= 8'h00;
			pin_s_q <= 8'h00;
		end else begin
			pin_m_q <= pin_i;
			pin_s_q <= pin_m_q;
		end
	end

	// sequencer: hold window, image copy, run
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		addr_d  = addr_q;
		slot_d  = slot_q;
		strap_d = strap_q;
		done_d  = done_q;
		wr_en   = 1'b0;
		wr_addr = addr_q;
		wr_data = pcg_pkg::DEFAULT_BYTE;
		case (state_q)
			ST_HOLD: begin
				cnt_d = cnt_q + 23'h000001;
				if (cnt_q == 23'(HOLD_CYC - 1)) begin
					// one-time capture of straps
					strap_d = {pin_s_q[2], pin_s_q[4], pin_s_q[3], pin_s_q[1], pin_s_q[0]};
					slot_d  = {pin_s_q[5], pin_s_q[6]};
					addr_d  = 10'h000;
					state_d = OTP_VALID ? ST_LOAD : ST_RUN; // defaults kept otherwise
					done_d  = !OTP_VALID;
				end
			end
			ST_LOAD: begin
				wr_en   = 1'b1; // image copy into store
				wr_data = otp_data_i;
				addr_d  = addr_q + 10'h001;
				if (addr_q == 10'(pcg_pkg::STORE_DEPTH - 1)) begin
					state_d = ST_RUN;
					done_d  = 1'b1;
				end
			end
			ST_RUN: begin
				// host writes only once loaded
				wr_en   = host_wr_i.valid;
				wr_addr = host_wr_i.addr;
				wr_data = host_wr_i.data;
			end
			default: state_d = ST_HOLD;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q <= ST_HOLD;
			cnt_q   <= 23'h000000;
			addr_q  <= 10'h000;
			slot_q  <= 2'h0;
			strap_q <= 5'h00;
			done_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			addr_q  <= addr_d;
			slot_q  <= slot_d;
			strap_q <= strap_d;
			done_q  <= done_d;
		end
	end

	// store: default fill on reset, volatile writes
	generate
		for (genvar i = 0; i < pcg_pkg::STORE_DEPTH; i++) begin : g_byte
			always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					store_q[i] <= pcg_pkg::DEFAULT_BYTE;
				end else if (wr_en && wr_addr == 10'(i)) begin
					store_q[i] <= wr_data;
				end
			end
		end
	endgenerate

	// host handshake and pin function decode
	always_comb begin
		ack_d = host_wr_i.valid && state_q == ST_RUN;
		rdv_d = host_rd_i.valid && state_q == ST_RUN;
		rd_d  = 8'h00;
		if (host_rd_i.valid && state_q == ST_RUN
		    && host_rd_i.addr < 10'(pcg_pkg::STORE_DEPTH)) begin
			rd_d = store_q[host_rd_i.addr];
		end
		// register bits first, pins OR-ed on top
		ctl_d.ref_loss = 8'h00;
		for (int t = 0; t < 4; t++) begin
			ctl_d.tie_clear[t] = store_q[pcg_pkg::OFS_LOOP_CTRL + 10'(t)]
			                     [pcg_pkg::LOOP_TIE_BIT];
		end
		ctl_d.halt_c[1] = store_q[pcg_pkg::OFS_SYNTH_HALT][pcg_pkg::HALT_C_B1_BIT];
		ctl_d.halt_c[0] = store_q[pcg_pkg::OFS_SYNTH_HALT][pcg_pkg::HALT_C_B0_BIT];
		// outputs off unless enabled; pin 2 strap forces output zero
		ctl_d.diff0_en  = store_q[pcg_pkg::OFS_DIFF_EN][pcg_pkg::DIFF0_BIT] || strap_q[4];
		for (int p = 0; p < pcg_pkg::NUM_PINS; p++) begin
			logic [6:0] fn;
			fn = store_q[pcg_pkg::OFS_PIN_FSEL + 10'(p)][pcg_pkg::FSEL_W-1:pcg_pkg::FSEL_LSB];
			// code FN_NONE and unknown codes attach nothing
			if (fn[6:3] == pcg_pkg::FN_LOS_BASE[6:3] && pin_s_q[p]) begin
				ctl_d.ref_loss[fn[2:0]] = 1'b1;
			end
			for (int t = 0; t < 4; t++) begin
				if (fn == 7'(pcg_pkg::FN_TIE0 + 7'(t) * pcg_pkg::FN_TIE_STEP) && pin_s_q[p]) begin
					ctl_d.tie_clear[t] = 1'b1;
				end
			end
			if (fn == pcg_pkg::FN_STOP_B1 && pin_s_q[p]) begin
				ctl_d.halt_c[1] = 1'b1;
			end
			if (fn == pcg_pkg::FN_STOP_B0 && pin_s_q[p]) begin
				ctl_d.halt_c[0] = 1'b1;
			end
		end
		if (state_q != ST_RUN) begin
			ctl_d = '0; // nothing steers until loaded
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ack_q <= 1'b0;
			rd_q  <= 8'h00;
			rdv_q <= 1'b0;
			ctl_q <= '0;
		end else begin
			ack_q <= ack_d;
			rd_q  <= rd_d;
			rdv_q <= rdv_d;
			ctl_q <= ctl_d;
		end
	end

	// registered outputs; clock choice from straps 1:0
	assign otp_slot_o    = slot_q;
	assign otp_addr_o    = addr_q;
	assign load_done_o   = done_q;
	assign host_wr_ack_o = ack_q;
	assign host_rd_o     = rd_q;
	assign host_rd_vld_o = rdv_q;
	assign mclk_sel_o    = pcg_pkg::pcg_mclk_t'(strap_q[1:0]);
	assign straps_o      = strap_q;
	assign ctl_o         = ctl_q;
endmodule : pcg_loader

// *** logic/pcg_pkg.sv ***
// package: constants and carrier types for the power-up configuration loader
package pcg_pkg;
	// store geometry
	localparam int unsigned STORE_DEPTH       = 768;
	localparam int unsigned ADDR_W            = 10;
	localparam int unsigned NUM_PINS          = 8;
	// timing
	localparam int unsigned CLK_HZ            = 20000000;
	localparam int unsigned STRAP_HOLD_MS     = 125;
	localparam int unsigned STRAP_HOLD_CYC    = CLK_HZ / 1000 * STRAP_HOLD_MS;
	// function-select field
	localparam int unsigned FSEL_LSB          = 0;
	localparam int unsigned FSEL_W            = 7;
	localparam logic [6:0]  FN_NONE           = 7'h00;
	localparam logic [6:0]  FN_LOS_BASE       = 7'h10;
	localparam logic [6:0]  FN_TIE0           = 7'h20;
	localparam logic [6:0]  FN_TIE_STEP       = 7'h08;
	localparam logic [6:0]  FN_STOP_B1        = 7'h44;
	localparam logic [6:0]  FN_STOP_B0        = 7'h45;
	// store offsets of the steering registers (arbitrary layout)
	localparam logic [9:0]  OFS_PIN_FSEL      = 10'h000;
	localparam logic [9:0]  OFS_LOOP_CTRL     = 10'h008;
	localparam logic [9:0]  OFS_SYNTH_HALT    = 10'h00c;
	localparam logic [9:0]  OFS_DIFF_EN       = 10'h00d;
	// field positions
	localparam int unsigned LOOP_TIE_BIT      = 0;
	localparam int unsigned HALT_C_B1_BIT     = 1;
	localparam int unsigned HALT_C_B0_BIT     = 0;
	localparam int unsigned DIFF0_BIT         = 0;
	// reset value of every byte with default source
	localparam logic [7:0]  DEFAULT_BYTE      = 8'h00;
	// clock selections
	typedef enum logic [1:0] {
		PCG_MCLK_24M576 = 2'h0,
		PCG_MCLK_49M152 = 2'h1,
		PCG_MCLK_20M    = 2'h2,
		PCG_MCLK_RSVD   = 2'h3
	} pcg_mclk_t;
	// host write request
	typedef struct packed {
		logic       valid;
		logic [9:0] addr;
		logic [7:0] data;
	} pcg_wr_t;
	// host read request
	typedef struct packed {
		logic       valid;
		logic [9:0] addr;
	} pcg_rd_t;
	// decoded control functions
	typedef struct packed {
		logic [7:0] ref_loss;
		logic [3:0] tie_clear;
		logic [1:0] halt_c;
		logic       diff0_en;
	} pcg_ctl_t;
endpackage : pcg_pkg

// *** tb/pcg_loader_assertions.sv ***
// checker: port-level properties of the configuration loader
module pcg_loader_assertions (
	input wire logic               sys_clk_i,     // clock
	input wire logic               reset_n_i,     // reset
	input wire pcg_pkg::pcg_wr_t   host_wr_i,     // host write
	input wire pcg_pkg::pcg_rd_t   host_rd_i,     // host read
	input wire logic [1:0]         otp_slot_o,    // image slot
	input wire logic               load_done_o,   // load finished
	input wire logic               host_wr_ack_o, // write ack
	input wire logic               host_rd_vld_o, // read valid
	input wire pcg_pkg::pcg_mclk_t mclk_sel_o,    // clock choice
	input wire logic [4:0]         straps_o,      // latched straps
	input wire pcg_pkg::pcg_ctl_t  ctl_o          // decoded control
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	// handshakes and load ordering
	property p_ack; host_wr_i.valid && load_done_o |=> host_wr_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("write not acknowledged");
	property p_noack; !load_done_o |=> !host_wr_ack_o; endproperty
	a_noack: assert property (p_noack) else $error("write taken during load");
	property p_rdv; host_rd_i.valid && load_done_o |=> host_rd_vld_o; endproperty
	a_rdv: assert property (p_rdv) else $error("read not answered");
	property p_done; $past(load_done_o) |-> load_done_o; endproperty
	a_done: assert property (p_done) else $error("load done dropped");
	// control outputs and latched straps
	property p_ctl0; !load_done_o |-> ctl_o == '0; endproperty
	a_ctl0: assert property (p_ctl0) else $error("control active before load");
	property p_mclk; load_done_o |-> mclk_sel_o == pcg_pkg::pcg_mclk_t'(straps_o[1:0]); endproperty
	a_mclk: assert property (p_mclk) else $error("clock choice mismatch");
	property p_strap; $past(load_done_o) |-> $stable(straps_o); endproperty
	a_strap: assert property (p_strap) else $error("straps changed after latch");
	property p_slot; $past(load_done_o) |-> $stable(otp_slot_o); endproperty
	a_slot: assert property (p_slot) else $error("slot changed after load");
	property p_diff; $past(load_done_o) && straps_o[4] |-> ctl_o.diff0_en; endproperty
	a_diff: assert property (p_diff) else $error("output zero not enabled");
	c_ack: cover property (host_wr_ack_o);
	c_halt: cover property (ctl_o.halt_c != 2'h0);
	c_loss: cover property (ctl_o.ref_loss != 8'h00);
endmodule : pcg_loader_assertions

// *** tb/pcg_loader_tb.sv ***
// testbench: boot, image slots, host access and pin function decode
module pcg_loader_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_i = 1'b0, reset_n_i = 1'b0, load_done_o, host_wr_ack_o, host_rd_vld_o;
	logic [7:0] pin_i = 8'h00, otp_data_i, host_rd_o, st, exp_q[$];
	logic [9:0] otp_addr_o;
	logic [1:0] otp_slot_o;
	logic [4:0] straps_o;
	logic [15:0] rnd = 16'hdfeb;
	pcg_pkg::pcg_wr_t host_wr_i = '0;
	pcg_pkg::pcg_rd_t host_rd_i = '0;
	pcg_pkg::pcg_mclk_t mclk_sel_o;
	pcg_pkg::pcg_ctl_t ctl_o;
	int fail_count = 0, comparisons = 0;
	// clock and design under test
	always #25 sys_clk_i = ~sys_clk_i;
	pcg_loader #(.HOLD_CYC(20), .OTP_VALID(1'b1)) DUT (.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i), .pin_i(pin_i), .host_wr_i(host_wr_i), .host_rd_i(host_rd_i),
		.otp_slot_o(otp_slot_o), .otp_addr_o(otp_addr_o), .otp_data_i(otp_data_i),
		.load_done_o(load_done_o), .host_wr_ack_o(host_wr_ack_o), .host_rd_o(host_rd_o),
		.host_rd_vld_o(host_rd_vld_o), .mclk_sel_o(mclk_sel_o), .straps_o(straps_o),
		.ctl_o(ctl_o));
	pcg_otp_model u_otp (.slot_i(otp_slot_o), .addr_i(otp_addr_o), .data_o(otp_data_i));
	function logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr
	function pcg_pkg::pcg_ctl_t ectl(input logic [6:0] c, input logic d);
		ectl = '0;
		ectl.diff0_en = d;
		if (c[6:3] == 4'h2) ectl.ref_loss[c[2:0]] = 1'b1;
		if (c[6:5] == 2'h1 && c[2:0] == 3'h0) ectl.tie_clear[c[4:3]] = 1'b1;
		if (c == 7'h44) ectl.halt_c[1] = 1'b1;
		if (c == 7'h45) ectl.halt_c[0] = 1'b1;
	endfunction : ectl
	task chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task complete_run;
		$display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : complete_run
	task wr(input logic [9:0] a, input logic [7:0] d);
		@(negedge sys_clk_i) host_wr_i = {1'b1, a, d};
		@(negedge sys_clk_i);
		chk(host_wr_ack_o, load_done_o);
		host_wr_i.valid = 1'b0;
	endtask : wr
	task rd(input logic [9:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		@(negedge sys_clk_i) host_rd_i = {1'b1, a};
		@(negedge sys_clk_i) host_rd_i.valid = 1'b0;
	endtask : rd
	// reset with random straps held through the load
	task boot;
		rnd = lfsr(rnd);
		st = {1'b0, rnd[6:0]};
		reset_n_i = 1'b0;
		pin_i = st;
		repeat (5) @(negedge sys_clk_i);
		reset_n_i = 1'b1;
		wr(10'h101, 8'h5a);
		for (int i = 0; i < 900 && load_done_o !== 1'b1; i++) @(negedge sys_clk_i);
		if (load_done_o !== 1'b1) begin
			fail_count++;
			complete_run();
		end
		// control outputs settle one cycle after the load ends
		@(negedge sys_clk_i);
	endtask : boot
	// read results against the oldest note
	always @(posedge sys_clk_i) begin
		#1;
		if (host_rd_vld_o === 1'b1) chk(host_rd_o, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
	end
	// hang guard
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		fail_count++;
		complete_run();
	end
	// main sequence
	initial begin
		boot();
		chk(straps_o, {st[2], st[4], st[3], st[1], st[0]});
		chk(mclk_sel_o, st[1:0]);
		chk(otp_slot_o, {st[5], st[6]});
		chk(ctl_o, ectl(7'h00, st[2]));
		pin_i = {1'b0, ~st[6:0]};
		repeat (4) @(negedge sys_clk_i);
		chk(straps_o, {st[2], st[4], st[3], st[1], st[0]});
		chk(ctl_o, ectl(7'h00, st[2]));
		rd(10'h101, {st[5], st[6], 6'h01});
		rd(10'h00d, 8'h00);
		rd(10'h2ff, {st[5], st[6], 6'h3f});
		rd(10'h300, 8'h00);
		rnd = lfsr(rnd);
		wr(10'h101, rnd[7:0]);
		rd(10'h101, rnd[7:0]);
		// every control-input code on pin 7, top bit random
		for (int i = 0; i < 15; i++) begin
			automatic logic [6:0] c = i == 0 ? 7'h00 : i < 9 ? 7'h0f + 7'(i) :
				i < 13 ? 7'h20 + 7'(8 * (i - 9)) : 7'h37 + 7'(i);
			rnd = lfsr(rnd);
			wr(10'h007, {rnd[0], c});
			pin_i[7] = 1'b1;
			repeat (4) @(negedge sys_clk_i);
			chk(ctl_o, ectl(c, st[2]));
			pin_i[7] = 1'b0;
			repeat (4) @(negedge sys_clk_i);
			chk(ctl_o, ectl(7'h00, st[2]));
		end
		wr(10'h008, 8'h01);
		wr(10'h00c, 8'h02);
		wr(10'h00d, 8'h01);
		repeat (3) @(negedge sys_clk_i);
		chk(ctl_o, {8'h00, 4'h1, 2'h2, 1'b1});
		pin_i[7] = 1'b1;
		repeat (4) @(negedge sys_clk_i);
		chk(ctl_o, {8'h00, 4'h1, 2'h3, 1'b1});
		boot();
		rd(10'h101, {st[5], st[6], 6'h01});
		chk(ctl_o, ectl(7'h00, st[2]));
		repeat (4) @(negedge sys_clk_i);
		complete_run();
	end
endmodule : pcg_loader_tb
bind pcg_loader pcg_loader_assertions u_chk (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
	.host_wr_i(host_wr_i), .host_rd_i(host_rd_i), .otp_slot_o(otp_slot_o),
	.load_done_o(load_done_o), .host_wr_ack_o(host_wr_ack_o), .host_rd_vld_o(host_rd_vld_o),
	.mclk_sel_o(mclk_sel_o), .straps_o(straps_o), .ctl_o(ctl_o));

// *** tb/pcg_otp_model.sv ***
// one-time image store model, combinational byte per slot and address
module pcg_otp_model (
	input  wire logic [1:0] slot_i, // image slot
	input  wire logic [9:0] addr_i, // byte address
	output logic      [7:0] data_o  // image byte
);
	timeunit 1ns;
	timeprecision 1ps;
	// steering bytes stay zero, others carry slot and address
	assign data_o = (addr_i < 10'h00e) ? 8'h00 : {slot_i, addr_i[5:0]};
endmodule : pcg_otp_model
